// [logic/lmms_sequencer.v]
`timescale 1ns/10ps
`include "lmms_consts.vh"
module lmms_sequencer #(
	parameter TICK_CYC = `LMMS_TICK_CYC,
	parameter COL_CYC  = `LMMS_COL_CYC
) (
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        movie_start,
	input  wire [5:0]  movie_first,
	input  wire [5:0]  movie_count,
	input  wire        end_last,
	output reg         movie_active,
	output reg  [5:0]  frame_addr,
	output reg         frame_step,
	output wire        fade_active,
	output wire        scroll_active,
	output wire        scroll_left,
	output wire        scroll_split,
	output reg  [11:0] column_enable,
	output reg  [3:0]  column_index,
	output reg         blink_phase,
	output wire [7:0]  drive_current
);
	reg [7:0]  frame_time_scroll_ctrl;
	reg [7:0]  display_option_ctrl;
	reg [7:0]  drive_current_level;
	reg [22:0] tick_cnt;
	reg        tick;
	reg [3:0]  hold_cnt;
	reg [2:0]  loop_cnt;
	reg [5:0]  frame_ofs;
	reg [7:0]  blink_cnt;
	reg [19:0] col_cnt;
	wire [3:0] delay    =
		frame_time_scroll_ctrl[`LMMS_FT_DELAY_HI:`LMMS_FT_DELAY_LO];
	wire [2:0] loops    =
		display_option_ctrl[`LMMS_DO_LOOPS_HI:`LMMS_DO_LOOPS_LO];
	wire [3:0] scan_lim =
		display_option_ctrl[`LMMS_DO_SCAN_HI:`LMMS_DO_SCAN_LO];
	// codes above the last column clamp to it
	wire [3:0] scan_top =
		(scan_lim > `LMMS_SCAN_MAX) ? `LMMS_SCAN_MAX : scan_lim;
	wire       hold_done;
	wire       last_frame;
	wire       last_loop;
	wire [7:0] blink_len;
	// register writes
	always @(posedge clk_sys) begin
		if (!nrst) begin
			frame_time_scroll_ctrl <= `LMMS_RST_FRAME_TIME;
			display_option_ctrl    <= `LMMS_RST_DISP_OPT;
			drive_current_level    <= `LMMS_RST_CURRENT;
		end else if (reg_wr) begin
			if (reg_addr == `LMMS_OFS_FRAME_TIME) begin
				frame_time_scroll_ctrl <= reg_wdata;
			end else if (reg_addr == `LMMS_OFS_DISP_OPT) begin
				display_option_ctrl <= reg_wdata;
			end else if (reg_addr == `LMMS_OFS_CURRENT) begin
				drive_current_level <= reg_wdata;
			end
		end
	end
	// register reads, unmapped reads zero
	always @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `LMMS_OFS_FRAME_TIME) begin
				reg_rdata <= frame_time_scroll_ctrl;
			end else if (reg_addr == `LMMS_OFS_DISP_OPT) begin
				reg_rdata <= display_option_ctrl;
			end else if (reg_addr == `LMMS_OFS_CURRENT) begin
				reg_rdata <= drive_current_level;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end
	assign drive_current = drive_current_level;
	// common 32.5 ms tick
	always @(posedge clk_sys) begin
		if (!nrst) begin
			tick_cnt <= 23'h000000;
			tick     <= 1'b0;
		end else if (movie_start && !movie_active) begin
			// restart the tick so the first frame gets a full hold
			tick_cnt <= 23'h000000;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_CYC - 1) begin
			tick_cnt <= 23'h000000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 23'h000001;
			tick     <= 1'b0;
		end
	end
	// code zero shows frame once with one tick
	assign hold_done = tick && (hold_cnt + 4'h1 >= delay);
	// movie_count is the number of frames less one
	assign last_frame = (frame_ofs >= movie_count);
	assign last_loop = (loops != `LMMS_LOOPS_ENDLESS) &&
		(loop_cnt + 3'h1 >= loops);
	// movie playback
	always @(posedge clk_sys) begin
		if (!nrst) begin
			movie_active <= 1'b0;
			frame_addr   <= 6'h00;
			frame_ofs    <= 6'h00;
			hold_cnt     <= 4'h0;
			loop_cnt     <= 3'h0;
			frame_step   <= 1'b0;
		end else begin
			frame_step <= 1'b0;
			if (movie_start && !movie_active) begin
				movie_active <= (loops != 3'h0);
				frame_addr   <= movie_first;
				frame_ofs    <= 6'h00;
				hold_cnt     <= 4'h0;
				loop_cnt     <= 3'h0;
			end else if (movie_active) begin
				if (!hold_done) begin
					if (tick) begin
						hold_cnt <= hold_cnt + 4'h1;
					end
				end else begin
					hold_cnt   <= 4'h0;
					frame_step <= 1'b1;
					if (!last_frame) begin
						frame_ofs  <= frame_ofs + 6'h01;
						frame_addr <= frame_addr + 6'h01;
					end else if (last_loop) begin
						movie_active <= 1'b0;
						if (!end_last) begin
							frame_addr <= movie_first;
						end
					end else begin
						// endless play leaves the loop count still
						if (loops != `LMMS_LOOPS_ENDLESS) begin
							loop_cnt <= loop_cnt + 3'h1;
						end
						frame_ofs  <= 6'h00;
						frame_addr <= movie_first;
					end
				end
			end
		end
	end
	// scroll and fade controls
	assign scroll_split = frame_time_scroll_ctrl[`LMMS_FT_BLOCK];
	assign scroll_left  = frame_time_scroll_ctrl[`LMMS_FT_DIR];
	assign scroll_active = movie_active &&
		frame_time_scroll_ctrl[`LMMS_FT_SCROLL];
	assign fade_active = frame_time_scroll_ctrl[`LMMS_FT_FADE] &&
		!scroll_split;
	// blink period from tick
	assign blink_len = display_option_ctrl[`LMMS_DO_BLINK] ?
		`LMMS_BLINK_LONG_TK : `LMMS_BLINK_SHORT_TK;
	always @(posedge clk_sys) begin
		if (!nrst) begin
			blink_cnt   <= 8'h00;
			blink_phase <= 1'b0;
		end else if (tick) begin
			if (blink_cnt + 8'h01 >= blink_len) begin
				blink_cnt   <= 8'h00;
				blink_phase <= ~blink_phase;
			end else begin
				blink_cnt <= blink_cnt + 8'h01;
			end
		end
	end
	// column scan, fixed dwell per column
	always @(posedge clk_sys) begin
		if (!nrst) begin
			col_cnt      <= 20'h00000;
			column_index <= 4'h0;
		end else if (col_cnt == COL_CYC - 1) begin
			col_cnt <= 20'h00000;
			if (column_index >= scan_top) begin
				column_index <= 4'h0;
			end else begin
				column_index <= column_index + 4'h1;
			end
		end else begin
			col_cnt <= col_cnt + 20'h00001;
		end
	end
	// enable mask for column 0 up to scan_top
	genvar g;
	generate
		for (g = 0; g < `LMMS_COLS; g = g + 1) begin : g_col
			always @(posedge clk_sys) begin
				if (!nrst) begin
					column_enable[g] <= 1'b0;
				end else begin
					column_enable[g] <= (g <= scan_top);
				end
			end
		end
	endgenerate
endmodule // lmms_sequencer

// [shared/lmms_consts.vh]
`ifndef LMMS_CONSTS_VH
`define LMMS_CONSTS_VH
// register offsets
`define LMMS_OFS_FRAME_TIME   8'h03
`define LMMS_OFS_DISP_OPT     8'h04
`define LMMS_OFS_CURRENT      8'h05
// reset values
`define LMMS_RST_FRAME_TIME   8'h00
`define LMMS_RST_DISP_OPT     8'h20
`define LMMS_RST_CURRENT      8'h00
// frame time register fields
`define LMMS_FT_FADE          7
`define LMMS_FT_DIR           6
`define LMMS_FT_BLOCK         5
`define LMMS_FT_SCROLL        4
`define LMMS_FT_DELAY_HI      3
`define LMMS_FT_DELAY_LO      0
// display option fields
`define LMMS_DO_LOOPS_HI      7
`define LMMS_DO_LOOPS_LO      5
`define LMMS_DO_BLINK         4
`define LMMS_DO_SCAN_HI       3
`define LMMS_DO_SCAN_LO       0
`define LMMS_LOOPS_ENDLESS    3'h7
`define LMMS_SCAN_MAX         4'hB
// timing
`define LMMS_CLK_HZ           10000000
`define LMMS_TICK_US          32500
`define LMMS_TICK_CYC         ((`LMMS_CLK_HZ / 1000) * `LMMS_TICK_US / 1000)
`define LMMS_REFRESH_HZ       430
`define LMMS_COLS             12
`define LMMS_FULL_SCAN_CYC    (`LMMS_CLK_HZ / `LMMS_REFRESH_HZ)
`define LMMS_COL_CYC          (`LMMS_FULL_SCAN_CYC / `LMMS_COLS)
`define LMMS_BLINK_SHORT_TK   8'h2E
`define LMMS_BLINK_LONG_TK    8'h5C
`endif

// [tb/led_matrix_movie_sequencer_bench.sv]
`timescale 1ns/10ps
module led_matrix_movie_sequencer_bench;
	reg         clk_sys, nrst, reg_wr, reg_rd, movie_start, end_last;
	reg  [7:0]  reg_addr, reg_wdata;
	reg  [5:0]  movie_first, movie_count;
	wire [7:0]  reg_rdata, drive_current;
	wire [5:0]  frame_addr;
	wire [11:0] column_enable;
	wire [3:0]  column_index;
	wire        movie_active, frame_step, fade_active, scroll_active;
	wire        scroll_left, scroll_split, blink_phase;
	integer     mismatches, cmp_count, n, i;
	reg         b;
	integer     cyc = 0;
	lmms_sequencer #(.TICK_CYC(10), .COL_CYC(4)) i_dut (
		.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.movie_start(movie_start), .movie_first(movie_first),
		.movie_count(movie_count), .end_last(end_last),
		.movie_active(movie_active), .frame_addr(frame_addr),
		.frame_step(frame_step), .fade_active(fade_active),
		.scroll_active(scroll_active), .scroll_left(scroll_left),
		.scroll_split(scroll_split), .column_enable(column_enable),
		.column_index(column_index), .blink_phase(blink_phase),
		.drive_current(drive_current));
	task chk(input [11:0] s, input [11:0] e); begin
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	end endtask
	task print_verdict; begin
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	end endtask
	task wr(input [7:0] a, input [7:0] d); begin
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
	end endtask
	task rd(input [7:0] a, input [7:0] e); begin
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		chk(reg_rdata, e);
	end endtask
	task start; begin
		movie_start <= 1'b1;
		@(posedge clk_sys);
		movie_start <= 1'b0;
		repeat (2) @(posedge clk_sys);
	end endtask
	task run_out; begin
		n = 0;
		i = 0;
		do begin
			@(negedge clk_sys);
			if (frame_step === 1'b1) n = n + 1;
			i = i + 1;
		end while (movie_active === 1'b1 && i < 3000);
		@(posedge clk_sys);
	end endtask
	task wait_toggle; begin
		b = blink_phase;
		i = 0;
		do begin
			@(negedge clk_sys);
			i = i + 1;
		end while (blink_phase === b && i < 3000);
		@(posedge clk_sys);
	end endtask
	task scan_probe; begin
		n = 0;
		i = 0;
		repeat (48) begin
			@(negedge clk_sys);
			if (column_index === 4'h0) n = n + 1;
			if (column_index > i) i = column_index;
		end
		@(posedge clk_sys);
	end endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			mismatches = mismatches + 1;
			print_verdict;
		end
	end
	initial begin
		{mismatches, cmp_count} = 0;
		{nrst, reg_wr, reg_rd, movie_start, end_last} <= 5'h00;
		{reg_addr, reg_wdata, movie_first, movie_count} <= 28'h0000000;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h20);
		rd(8'h05, 8'h00);
		wr(8'h06, 8'h5A);
		rd(8'h06, 8'h00);
		wait_toggle;
		wait_toggle;
		chk(i, 12'h1CC);
		wr(8'h04, 8'h30);
		wait_toggle;
		wait_toggle;
		chk(i, 12'h398);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'hFF);
		chk(drive_current, 8'hFF);
		wr(8'h03, 8'hB0);
		chk(fade_active, 1'b0);
		chk(scroll_split, 1'b1);
		wr(8'h03, 8'hC0);
		chk(fade_active, 1'b1);
		chk(scroll_left, 1'b1);
		chk(scroll_split, 1'b0);
		wr(8'h04, 8'h23);
		chk(column_enable, 12'h00F);
		scan_probe;
		chk(i, 12'h003);
		chk(n, 12'h00C);
		wr(8'h04, 8'h2F);
		chk(column_enable, 12'hFFF);
		scan_probe;
		chk(i, 12'h00B);
		chk(n, 12'h004);
		wr(8'h03, 8'h12);
		wr(8'h04, 8'h40);
		movie_first <= 6'h05;
		movie_count <= 6'h01;
		start;
		chk(scroll_active, 1'b1);
		chk(frame_addr, 6'h05);
		run_out;
		chk(n, 12'h004);
		chk(i, 12'h050);
		chk(frame_addr, 6'h05);
		chk(scroll_active, 1'b0);
		wr(8'h04, 8'h00);
		start;
		chk(movie_active, 1'b0);
		wr(8'h04, 8'hE0);
		start;
		repeat (300) @(posedge clk_sys);
		chk(movie_active, 1'b1);
		wr(8'h04, 8'h20);
		run_out;
		chk(movie_active, 1'b0);
		chk(i <= 12'h028, 1'b1);
		chk(frame_addr, 6'h05);
		end_last <= 1'b1;
		movie_first <= 6'h0A;
		movie_count <= 6'h02;
		wr(8'h03, 8'h00);
		start;
		chk(frame_addr, 6'h0A);
		run_out;
		chk(n, 12'h003);
		chk(i, 12'h01E);
		chk(frame_addr, 6'h0C);
		print_verdict;
	end
endmodule // led_matrix_movie_sequencer_bench
bind lmms_sequencer lmms_props i_props (.clk_sys(clk_sys), .nrst(nrst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.movie_active(movie_active), .frame_step(frame_step),
	.fade_active(fade_active), .scroll_active(scroll_active),
	.scroll_split(scroll_split), .column_enable(column_enable),
	.column_index(column_index), .blink_phase(blink_phase),
	.drive_current(drive_current));

// [tb/lmms_props.sv]
`timescale 1ns/10ps
module lmms_props (
	input wire        clk_sys,
	input wire        nrst,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	input wire        movie_active,
	input wire        frame_step,
	input wire        fade_active,
	input wire        scroll_active,
	input wire        scroll_split,
	input wire [11:0] column_enable,
	input wire [3:0]  column_index,
	input wire        blink_phase,
	input wire [7:0]  drive_current
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_quiet;
		!frame_step [*8];
	endsequence
	sequence s_cur_wr;
		reg_wr && reg_addr == 8'h05;
	endsequence
	chk_step_gap: assert property (frame_step |=> s_quiet)
		else $error("frame step too soon");
	chk_fade_split: assert property (fade_active |-> !scroll_split)
		else $error("fade in split mode");
	chk_scroll_play: assert property (scroll_active |-> movie_active)
		else $error("scroll while idle");
	chk_cur_write: assert property (s_cur_wr |=>
		drive_current == $past(reg_wdata)) else $error("current not set");
	chk_cur_read: assert property (reg_rd && !reg_wr &&
		reg_addr == 8'h05 |=> reg_rdata == drive_current)
		else $error("current read wrong");
	chk_col_span: assert property (
		$onehot0({1'b0, column_enable} + 13'h0001))
		else $error("columns not contiguous");
	chk_idx_range: assert property (column_index <= 4'hB)
		else $error("column index too high");
	chk_blink_hold: assert property ($changed(blink_phase) |=>
		$stable(blink_phase) [*8]) else $error("blink too fast");
endmodule // lmms_props
